// file: mam_top.sv
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps

// Overview of operation
// - cap life at or below 85 percent sets status bit 1.
// - write 1 arms; measuring starts only at supply power-off.
// - codes 0,1,2,3,8,9; writes of 3 and 8 rejected.
// - armed run at power-off drives test voltage for 1 s.
// - early power return may leave code 2; rearm by writing 1.
// - fan at or below half speed sets bit 2, warning, alarm.
// - any one fan at or below half speed raises the warning.
// - save hourly; timer field counts 100 hour units.
// - maintenance timer saturates at 9998 without wrapping.
// - timer read-only; writing 0 clears it.
// - spans under one whole hour are not counted.
// - timer at threshold raises maint alarm; 9999 disables.
// - maint alarm reaches a terminal only via code 95 or 195.
// - average pulse only on open-collector terminals via 93 or 193.
// - constant speed repeats 20 s pulse frames.
// - current averaged in 1 s start pulse over 0.1 to 1.0 s.
// - samples masked 0.0 to 20.0 s after reaching constant speed.
// - reference 0 to 500 A is the 100 percent point.
// - life alarm when any of four status bits is set.
// - current low pulse is avg/ref times 5 s, clamped 0.5 s to 9 s.
// - timer high pulse is timer*100/40000 h times 5 s, clamp 2 to 9 s.
// - accel or decel in start pulse gives 3.5 s high, 16.5 s low.
module mam_top import mam_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // ahb-lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    // drive status
    input  wire logic             supply_on,
    input  wire logic             const_speed,
    input  wire logic [9:0]       out_current_a,
    input  wire logic [1:0][6:0]  fan_speed_pct,
    input  wire logic             ctrl_cap_life_low,
    input  wire logic             inrush_life_low,
    // capacitor measurement front end
    input  wire logic             cap_meas_ok,
    input  wire logic [6:0]       cap_meas_pct,
    input  wire logic             cap_meas_forced,
    input  wire logic             cap_meas_err,
    output logic                  test_voltage_out,
    // alarms and terminals
    output logic                  fan_warning_display,
    output logic                  life_alarm_out,
    output logic                  maint_timer_alarm_out,
    output logic                  current_avg_pulse_out,
    output logic [2:0]            term_out,
    output logic                  nv_save
);

    mam_state_t s;
    mam_state_t next_s;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic term_drive(input logic [7:0] code,
                                        input logic relay,
                                        input logic life,
                                        input logic maint,
                                        input logic pulse);
        logic v;
        v = 1'b0;
        case (code)
            SEL_LIFE_P:  v = life;
            SEL_LIFE_N:  v = !life;
            SEL_MAINT_P: v = maint;
            SEL_MAINT_N: v = !maint;
            SEL_PULSE_P: v = !relay && pulse;
            SEL_PULSE_N: v = !relay && !pulse;
            default:     v = 1'b0;
        endcase
        return v;
    endfunction

    function automatic logic [6:0] cur_ticks(input logic [9:0] avg,
                                             input logic [8:0] ref_a);
        logic [19:0] a100;
        logic [19:0] q;
        a100 = 20'(avg) * 20'd100;
        q    = 20'd0;
        if (ref_a == 9'd0) begin
            q = 20'(PULSE_MAX_T);
        end else if (a100 < 20'(ref_a) * 20'(LOW_PCT)) begin
            q = 20'(CUR_MIN_T);
        end else if (a100 > 20'(ref_a) * 20'(HIGH_PCT)) begin
            q = 20'(PULSE_MAX_T);
        end else begin
            q = (20'(avg) * 20'(CUR_SCALE_T)) / 20'(ref_a);
        end
        return q[6:0];
    endfunction

    function automatic logic [6:0] tmr_ticks(input logic [13:0] t);
        logic [13:0] q;
        q = t / 14'(TMR_DIV);
        if (q < 14'(TMR_MIN_T)) begin
            q = 14'(TMR_MIN_T);
        end else if (q > 14'(PULSE_MAX_T)) begin
            q = 14'(PULSE_MAX_T);
        end
        return q[6:0];
    endfunction

    logic [3:0] status;
    logic       fan_low;
    logic       ap_take;
    logic [9:0] avg_a;

    assign fan_low = (fan_speed_pct[0] <= 7'(FAN_LIM_PCT))
                  || (fan_speed_pct[1] <= 7'(FAN_LIM_PCT));
    assign status  = {inrush_life_low, fan_low,
                      s.capv <= 7'(CAP_LIM_PCT),
                      ctrl_cap_life_low};
    assign ap_take = hsel && htrans[1] && hready;
    assign avg_a   = (s.n == 4'd0) ? 10'd0
                   : 10'(s.acc / 18'(s.n));

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s      = s;
        next_s.save = 1'b0;

        // register writes land in the data phase
        if (s.ap_wr) begin
            case (s.ap_addr)
                A_MEAS: begin
                    if (hwdata[3:0] == MS_ARMED
                        || hwdata[3:0] == MS_IDLE) begin
                        next_s.meas = hwdata[3:0];
                    end
                    // codes 3, 8 and the rest are rejected
                end
                A_TMR: begin
                    if (hwdata[13:0] == 14'd0) begin
                        next_s.tmr      = 14'd0;
                        next_s.hours    = 7'd0;
                        next_s.sub_hour = 16'd0;
                    end
                end
                A_THR: begin
                    if (hwdata[13:0] <= THR_OFF) begin
                        next_s.thr = hwdata[13:0];
                    end
                end
                A_WIN: begin
                    if (hwdata[3:0] >= WIN_MIN
                        && hwdata[3:0] <= WIN_RST) begin
                        next_s.win = hwdata[3:0];
                    end
                end
                A_MASK: begin
                    if (hwdata[7:0] <= MASK_MAX) begin
                        next_s.mask = hwdata[7:0];
                    end
                end
                A_IREF: begin
                    if (hwdata[8:0] <= IREF_MAX) begin
                        next_s.iref = hwdata[8:0];
                    end
                end
                A_SEL0: next_s.sel[0] = hwdata[7:0];
                A_SEL1: next_s.sel[1] = hwdata[7:0];
                A_SEL2: begin
                    // the relay contact cannot carry the pulse train
                    if (hwdata[7:0] != SEL_PULSE_P
                        && hwdata[7:0] != SEL_PULSE_N) begin
                        next_s.sel[RELAY_TERM] = hwdata[7:0];
                    end
                end
                default: ;
            endcase
        end

        // 0.1 s tick
        next_s.tick = 1'b0;
        if (s.pre == 24'(TICK_CYCLES - 1)) begin
            next_s.pre  = 24'd0;
            next_s.tick = 1'b1;
        end else begin
            next_s.pre = s.pre + 24'd1;
        end

        // capacitor measurement
        next_s.vout = 1'b0;
        if (!supply_on && s.meas == MS_ARMED) begin
            next_s.meas  = MS_RUN;
            next_s.vtest = 4'd0;
        end else if (s.meas == MS_RUN && !supply_on) begin
            if (s.vtest < 4'(VTEST_T)) begin
                next_s.vout = 1'b1;
                if (s.tick) begin
                    next_s.vtest = s.vtest + 4'd1;
                end
            end else if (cap_meas_err) begin
                next_s.meas = MS_ERR;
            end else if (cap_meas_forced) begin
                next_s.meas = MS_FORCED;
            end else if (cap_meas_ok) begin
                next_s.meas = MS_DONE;
                next_s.capv = cap_meas_pct;
            end
        end
        // early power return leaves the code at 2 until rearmed

        // energization time; only whole hours count
        if (!supply_on) begin
            next_s.sub_hour = 16'd0;
        end else if (s.tick) begin
            if (s.sub_hour == 16'(HOUR_T - 1)) begin
                next_s.sub_hour = 16'd0;
                next_s.save     = 1'b1;
                if (s.hours == 7'(HOURS_UNIT - 1)) begin
                    next_s.hours = 7'd0;
                    if (s.tmr < TMR_SAT) begin
                        next_s.tmr = s.tmr + 14'd1;
                    end
                end else begin
                    next_s.hours = s.hours + 7'd1;
                end
            end else begin
                next_s.sub_hour = s.sub_hour + 16'd1;
            end
        end

        // current average pulse frame
        next_s.was_const = const_speed;
        if (s.tick && s.cnt != 8'd0) begin
            next_s.cnt = s.cnt - 8'd1;
        end
        case (s.ph)
            PH_IDLE: begin
                if (const_speed && !s.was_const) begin
                    next_s.ph  = PH_MASK;
                    next_s.cnt = s.mask;
                end
            end
            PH_MASK: begin
                if (!const_speed) begin
                    next_s.ph = PH_IDLE;
                end else if (s.cnt == 8'd0 && s.pre == 24'd1) begin
                    // start on the tick grid so every phase is whole ticks
                    next_s.ph  = PH_START;
                    next_s.cnt = 8'(START_T);
                    next_s.acc = 18'd0;
                    next_s.n   = 4'd0;
                end
            end
            PH_START: begin
                if (!const_speed) begin
                    next_s.ph  = PH_INV_HI;
                    next_s.cnt = 8'(INV_HI_T - START_T) + s.cnt;
                end else if (s.cnt == 8'd0) begin
                    next_s.cur_t = cur_ticks(avg_a, s.iref);
                    next_s.tmr_t = tmr_ticks(s.tmr);
                    next_s.ph    = PH_CUR;
                    next_s.cnt   = 8'(cur_ticks(avg_a, s.iref));
                end else if (s.tick
                             && 4'(START_T) - 4'(s.cnt) < s.win) begin
                    next_s.acc = s.acc + 18'(out_current_a);
                    next_s.n   = s.n + 4'd1;
                end
            end
            PH_CUR: begin
                if (s.cnt == 8'd0) begin
                    next_s.ph  = PH_TMR;
                    next_s.cnt = 8'(s.tmr_t);
                end
            end
            PH_TMR: begin
                if (s.cnt == 8'd0) begin
                    next_s.ph  = PH_END;
                    next_s.cnt = 8'(FRAME_T - START_T)
                               - 8'(s.cur_t) - 8'(s.tmr_t);
                end
            end
            PH_INV_HI: begin
                if (s.cnt == 8'd0) begin
                    next_s.ph  = PH_INV_LO;
                    next_s.cnt = 8'(INV_LO_T);
                end
            end
            PH_END, PH_INV_LO: begin
                if (s.cnt == 8'd0) begin
                    if (const_speed) begin
                        next_s.ph  = PH_START;
                        next_s.cnt = 8'(START_T);
                        next_s.acc = 18'd0;
                        next_s.n   = 4'd0;
                    end else begin
                        next_s.ph = PH_IDLE;
                    end
                end
            end
            default: next_s.ph = PH_IDLE;
        endcase
        next_s.pulse = (next_s.ph == PH_START) || (next_s.ph == PH_TMR)
                    || (next_s.ph == PH_INV_HI);

        // alarms and terminals
        next_s.life  = |status;
        next_s.maint = (next_s.thr != THR_OFF)
                    && (next_s.tmr >= next_s.thr);
        for (int i = 0; i < 3; i++) begin
            next_s.term[i] = term_drive(next_s.sel[i], i == RELAY_TERM,
                                        next_s.life, next_s.maint,
                                        next_s.pulse);
        end

        // address phase; read data built from post-write values
        next_s.ap_wr = ap_take && hwrite;
        if (ap_take) begin
            next_s.ap_addr = haddr[5:0];
        end
        if (ap_take && !hwrite) begin
            case (haddr[5:0])
                A_MEAS:  next_s.rdata = 32'(next_s.meas);
                A_LIFE:  next_s.rdata = 32'(status);
                A_CAPV:  next_s.rdata = 32'(next_s.capv);
                A_TMR:   next_s.rdata = 32'(next_s.tmr);
                A_THR:   next_s.rdata = 32'(next_s.thr);
                A_WIN:   next_s.rdata = 32'(next_s.win);
                A_MASK:  next_s.rdata = 32'(next_s.mask);
                A_IREF:  next_s.rdata = 32'(next_s.iref);
                A_SEL0:  next_s.rdata = 32'(next_s.sel[0]);
                A_SEL1:  next_s.rdata = 32'(next_s.sel[1]);
                A_SEL2:  next_s.rdata = 32'(next_s.sel[2]);
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // supply_on drops clear sub_hour; hresetn loads the reset values into all state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s      <= '0;
            s.capv <= CAPV_RST;
            s.thr  <= THR_OFF;
            s.win  <= WIN_RST;
            s.mask <= MASK_RST;
            s.iref <= IREF_RST;
            s.ph   <= PH_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout             = 1'b1;
    assign hresp                 = 1'b0;
    assign hrdata                = s.rdata;
    assign test_voltage_out      = s.vout;
    assign fan_warning_display   = s.life && status[2];
    assign life_alarm_out        = s.life;
    assign maint_timer_alarm_out = s.maint;
    assign current_avg_pulse_out = s.pulse;
    assign term_out              = s.term;
    assign nv_save               = s.save;

endmodule

// file: mam_pkg.sv
package mam_pkg;

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    localparam int CLK_NS       = 50;
    localparam int TICK_NS      = 100_000_000;
    localparam int TICK_CYC     = TICK_NS / CLK_NS;
    localparam int TICKS_PER_S  = 10;
    localparam int VTEST_S      = 1;
    localparam int VTEST_T      = VTEST_S * TICKS_PER_S;
    localparam int HOUR_S       = 3600;
    localparam int HOUR_T       = HOUR_S * TICKS_PER_S;
    localparam int HOURS_UNIT   = 100;
    localparam int FRAME_S      = 20;
    localparam int FRAME_T      = FRAME_S * TICKS_PER_S;
    localparam int START_S      = 1;
    localparam int START_T      = START_S * TICKS_PER_S;
    localparam int INV_HI_MS    = 3500;
    localparam int INV_HI_T     = INV_HI_MS * TICKS_PER_S / 1000;
    localparam int INV_LO_MS    = 16500;
    localparam int INV_LO_T     = INV_LO_MS * TICKS_PER_S / 1000;
    localparam int CUR_SCALE_S  = 5;
    localparam int CUR_SCALE_T  = CUR_SCALE_S * TICKS_PER_S;
    localparam int CUR_MIN_MS   = 500;
    localparam int CUR_MIN_T    = CUR_MIN_MS * TICKS_PER_S / 1000;
    localparam int PULSE_MAX_S  = 9;
    localparam int PULSE_MAX_T  = PULSE_MAX_S * TICKS_PER_S;
    localparam int TMR_MIN_S    = 2;
    localparam int TMR_MIN_T    = TMR_MIN_S * TICKS_PER_S;
    localparam int TMR_FULL_H   = 40000;
    // timer pulse ticks = count * 100 * 50 / 40000 = count / 8
    localparam int TMR_DIV      = TMR_FULL_H / (HOURS_UNIT * CUR_SCALE_T);

    // ------------------------------------------------------------
    // limits and codes
    // ------------------------------------------------------------
    localparam int CAP_LIM_PCT  = 85;
    localparam int FAN_LIM_PCT  = 50;
    localparam int LOW_PCT      = 10;
    localparam int HIGH_PCT     = 180;
    localparam logic [13:0] TMR_SAT   = 14'd9998;
    localparam logic [13:0] THR_OFF   = 14'd9999;
    localparam logic [3:0]  MS_IDLE   = 4'h0;
    localparam logic [3:0]  MS_ARMED  = 4'h1;
    localparam logic [3:0]  MS_RUN    = 4'h2;
    localparam logic [3:0]  MS_DONE   = 4'h3;
    localparam logic [3:0]  MS_FORCED = 4'h8;
    localparam logic [3:0]  MS_ERR    = 4'h9;
    localparam logic [7:0]  SEL_LIFE_P  = 8'd90;
    localparam logic [7:0]  SEL_LIFE_N  = 8'd190;
    localparam logic [7:0]  SEL_PULSE_P = 8'd93;
    localparam logic [7:0]  SEL_PULSE_N = 8'd193;
    localparam logic [7:0]  SEL_MAINT_P = 8'd95;
    localparam logic [7:0]  SEL_MAINT_N = 8'd195;
    localparam int RELAY_TERM   = 2;

    // ------------------------------------------------------------
    // register map and reset values
    // ------------------------------------------------------------
    localparam logic [5:0] A_MEAS  = 6'h00;
    localparam logic [5:0] A_LIFE  = 6'h04;
    localparam logic [5:0] A_CAPV  = 6'h08;
    localparam logic [5:0] A_TMR   = 6'h0c;
    localparam logic [5:0] A_THR   = 6'h10;
    localparam logic [5:0] A_WIN   = 6'h14;
    localparam logic [5:0] A_MASK  = 6'h18;
    localparam logic [5:0] A_IREF  = 6'h1c;
    localparam logic [5:0] A_SEL0  = 6'h20;
    localparam logic [5:0] A_SEL1  = 6'h24;
    localparam logic [5:0] A_SEL2  = 6'h28;
    localparam logic [6:0] CAPV_RST = 7'd100;
    localparam logic [3:0] WIN_RST  = 4'd10;
    localparam logic [3:0] WIN_MIN  = 4'd1;
    localparam logic [7:0] MASK_RST = 8'd0;
    localparam logic [7:0] MASK_MAX = 8'd200;
    localparam logic [8:0] IREF_RST = 9'd10;
    localparam logic [8:0] IREF_MAX = 9'd500;

    typedef enum logic [2:0] {
        PH_IDLE, PH_MASK, PH_START, PH_CUR, PH_TMR, PH_END,
        PH_INV_HI, PH_INV_LO
    } mam_phase_t;

    typedef struct packed {
        logic [3:0]  meas;
        logic [6:0]  capv;
        logic [3:0]  vtest;
        logic [23:0] pre;
        logic        tick;
        logic [15:0] sub_hour;
        logic [6:0]  hours;
        logic [13:0] tmr;
        logic [13:0] thr;
        logic [3:0]  win;
        logic [7:0]  mask;
        logic [8:0]  iref;
        logic [2:0][7:0] sel;
        mam_phase_t  ph;
        logic [7:0]  cnt;
        logic [17:0] acc;
        logic [3:0]  n;
        logic [6:0]  cur_t;
        logic [6:0]  tmr_t;
        logic [2:0]  term;
        logic        pulse;
        logic        life;
        logic        maint;
        logic        save;
        logic        vout;
        logic        was_const;
        logic        ap_wr;
        logic [5:0]  ap_addr;
        logic [31:0] rdata;
    } mam_state_t;

endpackage

// file: mam_props.sv
`timescale 1ns/1ps
module mam_props import mam_pkg::*; #(
    parameter int TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic            hclk,
    input wire logic            hresetn,
    // observed
    input wire logic            hreadyout,
    input wire logic            hresp,
    input wire logic            supply_on,
    input wire logic [1:0][6:0] fan_speed_pct,
    input wire logic            ctrl_cap_life_low,
    input wire logic            inrush_life_low,
    input wire logic            test_voltage_out,
    input wire logic            fan_warning_display,
    input wire logic            life_alarm_out,
    input wire logic            current_avg_pulse_out
);
    localparam int TV_LO  = 9 * TICK_CYCLES + 1;
    localparam int TV_HI  = 10 * TICK_CYCLES + 1;
    localparam int HI_MIN = 10 * TICK_CYCLES;
    localparam int HI_MAX = 90 * TICK_CYCLES;
    logic [15:0] tv_cnt;
    logic [15:0] hi_cnt;
    logic        fan_low;
    assign fan_low = fan_speed_pct[0] <= 7'h32 || fan_speed_pct[1] <= 7'h32;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tv_cnt <= 16'h0;
            hi_cnt <= 16'h0;
        end else begin
            tv_cnt <= test_voltage_out ? tv_cnt + 16'h1 : 16'h0;
            hi_cnt <= current_avg_pulse_out ? hi_cnt + 16'h1 : 16'h0;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    chk_life_any: assert property (
        (ctrl_cap_life_low || inrush_life_low) |=> life_alarm_out)
        else $error("life alarm missing for status bit");
    chk_fan_alarm: assert property (fan_low |=> life_alarm_out)
        else $error("life alarm missing for slow fan");
    chk_fan_warn: assert property (fan_low |=> fan_warning_display)
        else $error("fan warning missing");
    chk_fan_quiet: assert property (!fan_low |-> !fan_warning_display)
        else $error("fan warning without slow fan");
    chk_tv_cause: assert property (
        $rose(test_voltage_out) |-> !$past(supply_on))
        else $error("test voltage while powered");
    chk_tv_len: assert property (
        $fell(test_voltage_out) |-> tv_cnt >= TV_LO && tv_cnt <= TV_HI)
        else $error("test voltage length wrong");
    chk_hi_grid: assert property (
        $fell(current_avg_pulse_out) |-> hi_cnt % TICK_CYCLES == 0)
        else $error("pulse high off the tick grid");
    chk_hi_span: assert property (
        $fell(current_avg_pulse_out) |-> hi_cnt >= HI_MIN && hi_cnt <= HI_MAX)
        else $error("pulse high length out of range");
    cov_tv: cover property ($fell(test_voltage_out));
    cov_pulse: cover property ($fell(current_avg_pulse_out));
    cov_fan: cover property (fan_low ##1 fan_warning_display);
endmodule
bind mam_top mam_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.*);

// file: mam_plc_input.sv
`timescale 1ns/1ps
// controller input: reports each finished run of one level, in clocks
module mam_plc_input (
    input  wire logic   hclk,
    input  wire logic   hresetn,
    input  wire logic   level,
    output logic        run_done,
    output logic [15:0] run_len
);
    logic        prev;
    logic [15:0] cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev     <= 1'b0;
            cnt      <= 16'h0;
            run_done <= 1'b0;
            run_len  <= 16'h0;
        end else begin
            prev     <= level;
            run_done <= level != prev;
            if (level != prev) begin
                run_len <= cnt;
                cnt     <= 16'h1;
            end else begin
                cnt <= cnt + 16'h1;
            end
        end
    end
endmodule

// file: test_maintenance_alarm_monitor.sv
`timescale 1ns/1ps
module test_maintenance_alarm_monitor import mam_pkg::*; ;
    localparam int T = 4;
    typedef struct packed {
        logic [5:0]  a;
        logic        w;
        logic [31:0] d;
        logic [31:0] e;
    } mam_row_t;
    mam_row_t rows[14] = '{
        '{A_MEAS, 1'b0, 32'h0, 32'h0}, '{A_CAPV, 1'b0, 32'h0, 32'h64},
        '{A_TMR, 1'b0, 32'h0, 32'h0}, '{A_THR, 1'b0, 32'h0, 32'h270f},
        '{A_WIN, 1'b0, 32'h0, 32'ha}, '{A_MASK, 1'b0, 32'h0, 32'h0},
        '{A_IREF, 1'b0, 32'h0, 32'ha}, '{A_MEAS, 1'b1, 32'h3, 32'h0},
        '{A_MEAS, 1'b1, 32'h8, 32'h0}, '{A_TMR, 1'b1, 32'h5, 32'h0},
        '{A_THR, 1'b1, 32'h2710, 32'h270f}, '{A_SEL2, 1'b1, 32'h5d, 32'h0},
        '{6'h30, 1'b1, 32'h5, 32'h0}, '{A_MEAS, 1'b1, 32'h1, 32'h1}};
    logic [15:0] exp_runs[5] = '{16'd40, 16'd300, 16'd80, 16'd380, 16'd140};
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize, term_out;
    logic supply_on, const_speed, cap_meas_ok, ctrl_low, inrush_low;
    logic test_voltage_out, fan_warn, life_out, maint_out, pulse_out;
    logic run_done;
    logic [15:0] run_len;
    logic [15:0] runs[$];
    logic [9:0] out_current_a;
    logic [6:0] cap_meas_pct;
    logic [1:0][6:0] fan_speed_pct;
    int miscompares;
    int samples_checked;
    assign hready = hreadyout;
    mam_top #(.TICK_CYCLES(T)) dut_u (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .supply_on(supply_on), .const_speed(const_speed),
        .out_current_a(out_current_a), .fan_speed_pct(fan_speed_pct),
        .ctrl_cap_life_low(ctrl_low), .inrush_life_low(inrush_low),
        .cap_meas_ok(cap_meas_ok), .cap_meas_pct(cap_meas_pct),
        .cap_meas_forced(1'b0), .cap_meas_err(1'b0),
        .test_voltage_out(test_voltage_out), .fan_warning_display(fan_warn),
        .life_alarm_out(life_out), .maint_timer_alarm_out(maint_out),
        .current_avg_pulse_out(pulse_out), .term_out(term_out),
        .nv_save());
    mam_plc_input plc_u (.hclk(hclk), .hresetn(hresetn),
        .level(term_out[0]), .run_done(run_done), .run_len(run_len));
    always @(posedge hclk) if (run_done) runs.push_back(run_len);
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic xfer(input logic [5:0] a, input logic w,
                        input logic [31:0] d);
        hsel <= 1'b1; haddr <= 32'(a); hwrite <= w; htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checked %0d, wrong %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        finish_test();
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
        {const_speed, cap_meas_ok, ctrl_low, inrush_low, cap_meas_pct} = '0;
        supply_on = 1'b1;
        out_current_a = 10'h00f;
        fan_speed_pct = {7'h64, 7'h64};
        hsize = 3'b010;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            if (rows[i].w) xfer(rows[i].a, 1'b1, rows[i].d);
            xfer(rows[i].a, 1'b0, 32'h0);
            check(r, rows[i].e);
        end
        xfer(A_SEL0, 1'b1, 32'h5f);
        xfer(A_SEL1, 1'b1, 32'hc3);
        xfer(A_THR, 1'b1, 32'h0);
        repeat (3) @(posedge hclk);
        check({term_out, maint_out}, 32'h3);
        xfer(A_THR, 1'b1, 32'h270f);
        repeat (3) @(posedge hclk);
        check(maint_out, 1'b0);
        // measurement runs only once the supply is gone
        supply_on <= 1'b0;
        repeat (200) if (test_voltage_out !== 1'b1) @(posedge hclk);
        repeat (200) if (test_voltage_out !== 1'b0) @(posedge hclk);
        cap_meas_pct <= 7'h50;
        cap_meas_ok <= 1'b1;
        repeat (4) @(posedge hclk);
        {cap_meas_ok, supply_on} <= 2'b01;
        repeat (3) @(posedge hclk);
        xfer(A_MEAS, 1'b0, 32'h0);
        check(r, 32'h3);
        xfer(A_CAPV, 1'b0, 32'h0);
        check(r, 32'h50);
        xfer(A_LIFE, 1'b0, 32'h0);
        check({r, life_out}, 33'h5);
        fan_speed_pct[1] <= 7'h28;
        repeat (3) @(posedge hclk);
        xfer(A_LIFE, 1'b0, 32'h0);
        check({r, fan_warn}, 33'hd);
        {ctrl_low, inrush_low} <= 2'b11;
        repeat (3) @(posedge hclk);
        xfer(A_LIFE, 1'b0, 32'h0);
        check(r, 32'hf);
        // two frames, the second spoiled by leaving constant speed
        xfer(A_SEL0, 1'b1, 32'h5d);
        xfer(A_SEL1, 1'b1, 32'hc1);
        runs.delete();
        const_speed <= 1'b1;
        repeat (3000) if (runs.size() < 5) @(posedge hclk);
        check({term_out[2], term_out[1] ^ term_out[0]}, 32'h1);
        repeat (200) if (pulse_out !== 1'b1) @(posedge hclk);
        repeat (4) @(posedge hclk);
        const_speed <= 1'b0;
        repeat (400) if (runs.size() < 6) @(posedge hclk);
        foreach (exp_runs[i]) begin
            check(32'(runs[i+1]), 32'(exp_runs[i]));
        end
        finish_test();
    end
endmodule
